// ===== design/nvm_pkg.sv
// Constants, types and state layout of the emulated non-volatile store
package nvm_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORDS = 32;
  localparam int unsigned WORD_W = 15;
  localparam int unsigned PAGE_WORDS = 16;
  localparam int unsigned UNIT_WORDS = 4;
  localparam int unsigned DATA_PAIRS = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned PROG_TIME_MIN_MS = 2;
  localparam int unsigned PROG_BASE_CYCLES =
    PROG_TIME_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 19;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses) and indices
  // ----------------------------------------------------------------
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] OFS_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_WORD0_LOW = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h24;
  localparam logic [3:0] IDX_ADDRESS = 4'h0;
  localparam logic [3:0] IDX_CONTROL = 4'h9;
  localparam logic [3:0] IDX_NONE = 4'hf;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_TSEL_LSB = 6;
  localparam int unsigned CTL_ERASE_EN = 5;
  localparam int unsigned CTL_ERASE_TRIG = 4;
  localparam int unsigned CTL_WRITE_EN = 3;
  localparam int unsigned CTL_WRITE_TRIG = 2;
  localparam int unsigned CTL_READ_EN = 1;
  localparam int unsigned CTL_READ_TRIG = 0;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDRESS_RST = 5'h00;
  localparam logic [7:0] DATA_LOW_RST = 8'h00;
  localparam logic [6:0] DATA_HIGH_RST = 7'h00;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_READ} op_e;

  typedef struct packed {
    logic [WORDS-1:0][WORD_W-1:0] mem;
    logic [4:0] addr;
    logic [DATA_PAIRS-1:0][7:0] lo;
    logic [DATA_PAIRS-1:0][6:0] hi;
    logic [1:0] tsel;
    logic erase_enable;
    logic erase_trigger;
    logic write_enable;
    logic write_trigger;
    logic read_enable;
    logic read_trigger;
    logic arm_erase;
    logic arm_write;
    op_e op;
    logic [CNT_W-1:0] cnt;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic stall;
  } st_s;

endpackage

// ===== design/emulated_nvm_controller.sv
// Emulated non-volatile data store with AXI4-Lite register access
//
// Overview of operation
// - Store 32 words of 15 bits; array keeps contents across reset.
// - Erase clears a 16-word page, write programs 4 words, read one.
// - Erase page chosen by address bit 4 only.
// - Write unit chosen by address bits 4..2; bits 1..0 ignored.
// - Address register holds 5 bits; upper three read as zero.
// - Four data words, low byte plus 7-bit high part, bit 7 zero.
// - Time select 00/01/10/11 gives 2/4/8/16 ms for erase and write.
// - Erase enable needed for erase; hardware clears it when done.
// - Erase trigger starts erase, cleared by hardware on completion.
// - Erase trigger ignored unless erase enable was set earlier.
// - Write enable needed for write; hardware clears it when done.
// - Write trigger starts write, cleared by hardware on completion.
// - Write trigger ignored unless write enable was set earlier.
// - Read enable needed; reads inhibited while it is clear.
// - Read trigger starts read, cleared by hardware on completion.
// - Read trigger ignored unless read enable was set earlier.
// - Erase/write trigger must come in the write right after enable.
// - Erased page reads back as all zero.
// - Read word lands in data pair 0, kept until the next read or a write to that pair.
// - Processor stalled from a started operation until it ends.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module emulated_nvm_controller #(
  parameter int unsigned PROG_BASE_CYCLES = nvm_pkg::PROG_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [nvm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [nvm_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpu_stall
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Register index of a byte address, or none
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    logic [3:0] idx;
    idx = a[5:2];
    if (a[7:6] != 2'h0 || idx > nvm_pkg::IDX_CONTROL) begin
      idx = nvm_pkg::IDX_NONE;
    end
    return idx;
  endfunction

  // Erase/write duration in cycles, doubling per select step
  function automatic logic [nvm_pkg::CNT_W-1:0] prog_cycles(
    input logic [1:0] tsel);
    logic [nvm_pkg::CNT_W-1:0] base;
    base = nvm_pkg::CNT_W'(PROG_BASE_CYCLES);
    return base << tsel;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nvm_pkg::st_s st_r;
  nvm_pkg::st_s st_nxt;

  // Read image of one register
  function automatic logic [31:0] reg_value(input nvm_pkg::st_s s,
                                           input logic [3:0] idx);
    logic [31:0] v;
    logic [1:0] k;
    v = 32'h0000_0000;
    k = 2'((idx - 4'h1) >> 1);
    if (idx == nvm_pkg::IDX_ADDRESS) begin
      v[4:0] = s.addr;
    end else if (idx == nvm_pkg::IDX_CONTROL) begin
      v[nvm_pkg::CTL_TSEL_LSB+:2] = s.tsel;
      v[nvm_pkg::CTL_ERASE_EN] = s.erase_enable;
      v[nvm_pkg::CTL_ERASE_TRIG] = s.erase_trigger;
      v[nvm_pkg::CTL_WRITE_EN] = s.write_enable;
      v[nvm_pkg::CTL_WRITE_TRIG] = s.write_trigger;
      v[nvm_pkg::CTL_READ_EN] = s.read_enable;
      v[nvm_pkg::CTL_READ_TRIG] = s.read_trigger;
    end else if (idx != nvm_pkg::IDX_NONE) begin
      if (idx[0]) begin
        v[7:0] = s.lo[k];
      end else begin
        v[6:0] = s.hi[k];
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic aw_hs;
    logic w_hs;
    logic have_aw;
    logic have_w;
    logic [7:0] wa;
    logic [7:0] wd;
    logic ws;
    logic [3:0] idx;
    logic [1:0] k;
    logic busy;
    logic go_e;
    logic go_w;
    logic go_r;
    aw_hs = s_axi_awvalid && st_r.awready;
    w_hs = s_axi_wvalid && st_r.wready;
    have_aw = st_r.aw_got || aw_hs;
    have_w = st_r.w_got || w_hs;
    wa = aw_hs ? s_axi_awaddr : st_r.awaddr;
    wd = w_hs ? s_axi_wdata[7:0] : st_r.wdata;
    ws = w_hs ? s_axi_wstrb[0] : st_r.wstrb0;
    idx = reg_sel(wa);
    k = 2'((idx - 4'h1) >> 1);
    busy = st_r.op != nvm_pkg::OP_IDLE;
    go_e = 1'b0;
    go_w = 1'b0;
    go_r = 1'b0;
    st_nxt = st_r;

    // Running operation
    case (st_r.op)
      nvm_pkg::OP_ERASE: begin
        if (st_r.cnt == '0) begin
          for (int i = 0; i < nvm_pkg::PAGE_WORDS; i++) begin
            st_nxt.mem[{st_r.addr[4], 4'(i)}] = '0;
          end
          st_nxt.erase_enable = 1'b0;
          st_nxt.erase_trigger = 1'b0;
          st_nxt.op = nvm_pkg::OP_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      nvm_pkg::OP_WRITE: begin
        if (st_r.cnt == '0) begin
          for (int i = 0; i < nvm_pkg::UNIT_WORDS; i++) begin
            st_nxt.mem[{st_r.addr[4:2], 2'(i)}] =
              {st_r.hi[i], st_r.lo[i]};
          end
          st_nxt.write_enable = 1'b0;
          st_nxt.write_trigger = 1'b0;
          st_nxt.op = nvm_pkg::OP_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      nvm_pkg::OP_READ: begin
        st_nxt.lo[0] = st_r.mem[st_r.addr][7:0];
        st_nxt.hi[0] = st_r.mem[st_r.addr][14:8];
        st_nxt.read_trigger = 1'b0;
        st_nxt.op = nvm_pkg::OP_IDLE;
      end
      default: begin
        st_nxt.op = nvm_pkg::OP_IDLE;
      end
    endcase

    // Write channel capture
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end

    // Register write once address and data are both in
    if (have_aw && have_w && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (idx == nvm_pkg::IDX_NONE) ?
        nvm_pkg::RESP_SLVERR : nvm_pkg::RESP_OKAY;
      // Writes while busy are dropped so the operation sees stable data
      if (!busy && ws && idx != nvm_pkg::IDX_NONE) begin
        st_nxt.arm_erase = 1'b0;
        st_nxt.arm_write = 1'b0;
        if (idx == nvm_pkg::IDX_ADDRESS) begin
          st_nxt.addr = wd[4:0];
        end else if (idx == nvm_pkg::IDX_CONTROL) begin
          go_e = wd[nvm_pkg::CTL_ERASE_TRIG] && wd[nvm_pkg::CTL_ERASE_EN] &&
                 st_r.erase_enable && st_r.arm_erase;
          go_w = wd[nvm_pkg::CTL_WRITE_TRIG] && wd[nvm_pkg::CTL_WRITE_EN] &&
                 st_r.write_enable && st_r.arm_write && !go_e;
          go_r = wd[nvm_pkg::CTL_READ_TRIG] && wd[nvm_pkg::CTL_READ_EN] &&
                 st_r.read_enable && !go_e && !go_w;
          st_nxt.tsel = wd[nvm_pkg::CTL_TSEL_LSB+:2];
          st_nxt.erase_enable = wd[nvm_pkg::CTL_ERASE_EN];
          st_nxt.write_enable = wd[nvm_pkg::CTL_WRITE_EN];
          st_nxt.read_enable = wd[nvm_pkg::CTL_READ_EN];
          st_nxt.erase_trigger = go_e;
          st_nxt.write_trigger = go_w;
          st_nxt.read_trigger = go_r;
          st_nxt.arm_erase = wd[nvm_pkg::CTL_ERASE_EN] &&
                             !wd[nvm_pkg::CTL_ERASE_TRIG];
          st_nxt.arm_write = wd[nvm_pkg::CTL_WRITE_EN] &&
                             !wd[nvm_pkg::CTL_WRITE_TRIG];
          if (go_e) begin
            st_nxt.op = nvm_pkg::OP_ERASE;
            st_nxt.cnt = prog_cycles(wd[nvm_pkg::CTL_TSEL_LSB+:2]) - 1'b1;
          end else if (go_w) begin
            st_nxt.op = nvm_pkg::OP_WRITE;
            st_nxt.cnt = prog_cycles(wd[nvm_pkg::CTL_TSEL_LSB+:2]) - 1'b1;
          end else if (go_r) begin
            st_nxt.op = nvm_pkg::OP_READ;
          end
        end else if (idx[0]) begin
          st_nxt.lo[k] = wd;
        end else begin
          st_nxt.hi[k] = wd[6:0];
        end
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

    // Read channel
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = reg_value(st_r, reg_sel(s_axi_araddr));
      st_nxt.rresp = (reg_sel(s_axi_araddr) == nvm_pkg::IDX_NONE) ?
        nvm_pkg::RESP_SLVERR : nvm_pkg::RESP_OKAY;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Processor held while an operation runs
    st_nxt.stall = st_nxt.op != nvm_pkg::OP_IDLE;
  end

  // ----------------------------------------------------------------
  // State register; array left untouched by reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.addr <= nvm_pkg::ADDRESS_RST;
      st_r.lo <= {nvm_pkg::DATA_PAIRS{nvm_pkg::DATA_LOW_RST}};
      st_r.hi <= {nvm_pkg::DATA_PAIRS{nvm_pkg::DATA_HIGH_RST}};
      st_r.tsel <= nvm_pkg::TSEL_RST;
      st_r.mem <= st_r.mem;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign cpu_stall = st_r.stall;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  erase_gate_a: assert property (
    $rose(st_r.erase_trigger) |->
      $past(st_r.erase_enable) && $past(st_r.arm_erase))
    else $error("erase started without prior enable");

  write_gate_a: assert property (
    $rose(st_r.write_trigger) |->
      $past(st_r.write_enable) && $past(st_r.arm_write))
    else $error("write started without prior enable");

  read_gate_a: assert property (
    $rose(st_r.read_trigger) |-> $past(st_r.read_enable))
    else $error("read started without read enable");

  erase_end_a: assert property (
    (st_r.op == nvm_pkg::OP_ERASE && st_r.cnt == '0) |=>
      !st_r.erase_enable && !st_r.erase_trigger &&
      st_r.op == nvm_pkg::OP_IDLE)
    else $error("erase end did not clear enable and trigger");

  page_zero_a: assert property (
    (st_r.op == nvm_pkg::OP_ERASE && st_r.cnt == '0) |=>
      st_r.mem[{$past(st_r.addr[4]), 4'h0}] == '0 &&
      st_r.mem[{$past(st_r.addr[4]), 4'hf}] == '0)
    else $error("erased page not zero");

  read_load_a: assert property (
    (st_r.op == nvm_pkg::OP_READ) |=>
      {st_r.hi[0], st_r.lo[0]} == $past(st_r.mem[st_r.addr]) &&
      !st_r.read_trigger)
    else $error("read word not placed in pair 0");

  prog_time_a: assert property (
    (st_r.op == nvm_pkg::OP_IDLE ##1 st_r.op == nvm_pkg::OP_ERASE) |->
      st_r.cnt == prog_cycles(st_r.tsel) - 1'b1)
    else $error("erase duration not loaded from time select");

  one_op_a: assert property (
    (st_r.op != nvm_pkg::OP_IDLE && $past(st_r.op) != nvm_pkg::OP_IDLE)
      |-> st_r.op == $past(st_r.op))
    else $error("operation changed while busy");

  stall_match_a: assert property (
    (st_r.op != nvm_pkg::OP_IDLE) == st_r.stall)
    else $error("stall does not follow the running operation");

  write_end_a: assert property (
    (st_r.op == nvm_pkg::OP_WRITE && st_r.cnt == '0) |=>
      !st_r.write_enable && !st_r.write_trigger &&
      st_r.op == nvm_pkg::OP_IDLE)
    else $error("write end did not clear enable and trigger");

  unit_prog_a: assert property (
    (st_r.op == nvm_pkg::OP_WRITE && st_r.cnt == '0) |=>
      st_r.mem[{$past(st_r.addr[4:2]), 2'h0}] ==
        $past({st_r.hi[0], st_r.lo[0]}) &&
      st_r.mem[{$past(st_r.addr[4:2]), 2'h3}] ==
        $past({st_r.hi[3], st_r.lo[3]}))
    else $error("write unit not programmed from the data pairs");

  write_time_a: assert property (
    (st_r.op == nvm_pkg::OP_IDLE ##1 st_r.op == nvm_pkg::OP_WRITE) |->
      st_r.cnt ==
        nvm_pkg::CNT_W'((PROG_BASE_CYCLES << st_r.tsel) - 1))
    else $error("write duration not loaded from time select");

  stall_start_a: assert property (
    $rose(st_r.stall) |-> $rose(st_r.bvalid))
    else $error("stall rose without a control write answer");

  busy_hold_a: assert property (
    (st_r.op != nvm_pkg::OP_IDLE) |=>
      $stable(st_r.addr) && $stable(st_r.tsel))
    else $error("register changed while an operation ran");

  read_width_a: assert property (
    $rose(st_r.rvalid) |-> st_r.rdata[31:8] == 24'h0)
    else $error("read data wider than the register");

  cover_erase: cover property (
    st_r.op == nvm_pkg::OP_ERASE ##1 st_r.op == nvm_pkg::OP_IDLE);
  cover_write: cover property (
    st_r.op == nvm_pkg::OP_WRITE ##1 st_r.op == nvm_pkg::OP_IDLE);
  cover_read: cover property (st_r.op == nvm_pkg::OP_READ);
  cover_refused: cover property (
    st_r.bvalid && !st_r.erase_trigger && !st_r.arm_erase &&
    st_r.erase_enable);

endmodule

// ===== verif/emulated_nvm_controller_tb.sv
// Self-checking bench for the emulated non-volatile store
`timescale 1ns/1ps
module emulated_nvm_controller_tb;
  localparam int BASE = 8;
  logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpu_stall;
  logic [7:0] awaddr, araddr, addr_m;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [14:0] mem_m [32];
  logic [7:0] arms [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h08};
  logic [7:0] fires [6] = '{8'h30, 8'h0c, 8'h01, 8'h03, 8'h30, 8'h0c};
  int n_fail, checked, stall_cnt;

  emulated_nvm_controller #(.PROG_BASE_CYCLES(BASE)) uut (
    .clk(clk),
    .srst(srst),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .cpu_stall(cpu_stall)
  );

  // ----------------------------------------------------------------
  // Clock, watchdog, stall counter and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  // Counts busy cycles of the current operation
  always @(posedge clk) begin
    if (cpu_stall === 1'b1) stall_cnt++;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic final_report;
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write one register; checks that the answer comes with code er
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    forever begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 || n > 200) break;
    end
    bready <= 1'b0;
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, bvalid, bresp});
  endtask

  // Read one register and compare data and response code
  task automatic rdck(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    forever begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 || n > 200) break;
    end
    rready <= 1'b0;
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, rvalid, rresp});
    chk("rdata", exp, rdata);
  endtask

  // Arm and fire through control; poke writes the address while busy
  task automatic op(input logic [7:0] arm, fire, input bit poke, mid);
    int n;
    wr(8'h24, arm, 2'h0);
    if (mid) wr(8'h00, addr_m, 2'h0);
    stall_cnt = 0;
    wr(8'h24, fire, 2'h0);
    if (poke) wr(8'h00, addr_m ^ 8'h1f, 2'h0);
    n = 0;
    while (cpu_stall !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    srst = 1'b1;
    rnd = 32'd1063;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // Reset values, unmapped place, unimplemented bits
    for (int i = 0; i < 10; i++) rdck(8'(4 * i), 32'h0, 2'h0);
    rdck(8'h28, 32'h0, 2'h2);
    wr(8'h28, 8'hff, 2'h2);
    wr(8'h00, 8'hff, 2'h0);
    rdck(8'h00, 32'h1f, 2'h0);
    wr(8'h08, 8'hff, 2'h0);
    rdck(8'h08, 32'h7f, 2'h0);
    // Erase with every time select; last pass clears page 0 again
    for (int k = 0; k < 5; k++) begin
      rnd = xs(rnd);
      addr_m = {3'h0, k[0], rnd[3:0]};
      wr(8'h00, addr_m, 2'h0);
      op({k[1:0], 6'h20}, {k[1:0], 6'h30}, 1'b1, 1'b0);
      chk("cycles", 32'(BASE << k[1:0]), stall_cnt);
      rdck(8'h24, {24'h0, k[1:0], 6'h0}, 2'h0);
      rdck(8'h00, {24'h0, addr_m}, 2'h0);
      for (int w = 0; w < 16; w++) mem_m[{k[0], 4'(w)}] = 15'h0;
      // Program every unit once, after the fourth erase pass
      for (int u = 0; u < 8 && k == 3; u++) begin
        for (int i = 0; i < 4; i++) begin
          rnd = xs(rnd);
          mem_m[{u[2:0], i[1:0]}] = rnd[14:0];
          wr(8'(4 + 8 * i), rnd[7:0], 2'h0);
          wr(8'(8 + 8 * i), rnd[15:8], 2'h0);
        end
        addr_m = {3'h0, u[2:0], rnd[17:16]};
        wr(8'h00, addr_m, 2'h0);
        op(8'h08, 8'h0c, 1'b1, 1'b0);
        chk("cycles", BASE, stall_cnt);
        rdck(8'h24, 32'h0, 2'h0);
      end
    end
    // Triggers that must be ignored start no operation and leave data pair 0 unchanged
    wr(8'h04, 8'h5a, 2'h0);
    // Byte lane 0 off: answered but dropped
    wstrb <= 4'he;
    wr(8'h04, 8'ha5, 2'h0);
    wstrb <= 4'hf;
    for (int i = 0; i < 6; i++) begin
      op(arms[i], fires[i], 1'b0, i > 3);
      chk("ignored", 32'h0, stall_cnt);
    end
    rdck(8'h04, 32'h5a, 2'h0);
    // Mid-run reset clears registers but keeps the array
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdck(8'h04, 32'h0, 2'h0);
    rdck(8'h24, 32'h0, 2'h0);
    // Read back the whole array one word at a time
    for (int w = 0; w < 32; w++) begin
      addr_m = 8'(w);
      wr(8'h00, addr_m, 2'h0);
      op(8'h02, 8'h03, 1'b0, 1'b0);
      chk("cycles", 32'h1, stall_cnt);
      rdck(8'h24, 32'h02, 2'h0);
      rdck(8'h04, {24'h0, mem_m[w][7:0]}, 2'h0);
      rdck(8'h08, {25'h0, mem_m[w][14:8]}, 2'h0);
    end
    final_report();
  end
endmodule
